//--- core/lsw_segment_map.v
// segment pattern map for panel pins 50..63 with phase sequencer
// assumes an apb master on pclk and an analog stage that turns the
// per-pin drive codes into bias levels
//
// Behaviour
// - an enabled frontplane pin shows a segment on for 1, off for 0.
// - an enabled backplane pin is active in phase y only when bit y is 1.
// - bit y of phase_backplane_r is set when any shown backplane pin is active in phase y.
// - a pin drives only when its enable and the global enable are set.
// - a pin with backplane select set is a backplane, else a frontplane.
// - in blank mode the patterns are ignored and all segments are off.
// - the duty field codes 0..7 give 1..8 phases starting at A.
// - the sequencer steps the enabled phases and repeats every frame.
//
// The APB interface to the registers and the address map were decided locally.
`timescale 1ns/10ps
`include "lsw_defines.vh"

module lsw_segment_map
(
   input  wire        pclk,
   input  wire        presetn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   output reg  [13:0] pin_active_r,
   output reg  [13:0] pin_is_bp_r,
   output reg  [13:0] pin_level_r,
   output reg  [7:0]  phase_backplane_r,
   output reg         frame_start_r
);

   // ******************************************************
   // decode helpers
   // ******************************************************
   function [4:0] pat_index;
      input [11:0] a;
      reg   [11:0] d;
      begin
         d = a - `LSW_OFS_PAT_BASE;
         if (a >= `LSW_OFS_PAT_BASE && a <= `LSW_OFS_PAT_LAST
             && a[1:0] == 2'b00)
            pat_index = {1'b0, d[5:2]};
         else
            pat_index = 5'h1F;
      end
   endfunction

   // one decode for every fixed register, so they cannot drift apart
   function reg_hit;
      input [11:0] a;
      input [11:0] ofs;
      begin
         reg_hit = (a == ofs);
      end
   endfunction

   // ******************************************************
   // registers
   // ******************************************************
   reg  [7:0]  ctrl_r;
   reg  [13:0] pen_r;
   reg  [13:0] bpsel_r;
   reg  [7:0]  segment_pattern_regs [0:13];
   reg  [2:0]  phase_r;
   reg  [15:0] tick_r;

   wire        access = psel & penable;
   wire [4:0]  pidx   = pat_index(paddr);
   wire        is_pat = (pidx != 5'h1F);
   wire        is_ctl = reg_hit(paddr, `LSW_OFS_CTRL);
   wire        is_pen = reg_hit(paddr, `LSW_OFS_PEN);
   wire        is_bps = reg_hit(paddr, `LSW_OFS_BPSEL);
   wire        is_sts = reg_hit(paddr, `LSW_OFS_STATUS);
   wire        mapped = is_pat | is_ctl | is_pen | is_bps | is_sts;

   wire        drv_en = ctrl_r[`LSW_CTRL_EN_BIT];
   wire        blank  = ctrl_r[`LSW_CTRL_BLANK_BIT];
   wire [2:0]  duty   = ctrl_r[`LSW_CTRL_DUTY_HI:`LSW_CTRL_DUTY_LO];

   // ******************************************************
   // read mux
   // ******************************************************
   // unmapped addresses read as zero
   reg  [31:0] rd_nxt;

   always @*
   begin
      rd_nxt = 32'h0000_0000;
      if (is_ctl)
         rd_nxt = {24'h00_0000, ctrl_r};
      else if (is_pen)
         rd_nxt = {18'h0_0000, pen_r};
      else if (is_bps)
         rd_nxt = {18'h0_0000, bpsel_r};
      else if (is_sts)
         rd_nxt = {16'h0000, 5'h00, phase_r, phase_backplane_r};
      else if (is_pat)
         rd_nxt = {24'h00_0000, segment_pattern_regs[pidx[3:0]]};
   end

   // ******************************************************
   // apb slave: one wait-free access phase, error on unmapped
   // ******************************************************
   // ready rises in every access phase, so a master never waits
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end
      else
      begin
         pready  <= psel & ~penable;
         pslverr <= psel & ~penable & ~mapped;
      end
   end

   // ******************************************************
   // control registers
   // ******************************************************
   // unmapped writes fall through every compare and are dropped
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl_r  <= `LSW_CTRL_RESET;
         pen_r   <= 14'h0000;
         bpsel_r <= 14'h0000;
      end
      else if (access & pready & pwrite)
      begin
         if (is_ctl)
            ctrl_r <= pwdata[7:0];
         if (is_pen)
            pen_r <= pwdata[13:0];
         if (is_bps)
            bpsel_r <= pwdata[13:0];
      end
   end

   // ******************************************************
   // read data
   // ******************************************************
   // captured in the setup cycle so it stands for the access phase
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata <= 32'h0000_0000;
      else if (psel & ~penable & ~pwrite)
         prdata <= rd_nxt;
   end

   // ******************************************************
   // pattern memory
   // ******************************************************
   // pattern memory is not reset, contents undefined until written
   always @(posedge pclk)
   begin
      if (access & pready & pwrite & is_pat)
         segment_pattern_regs[pidx[3:0]] <= pwdata[7:0];
   end

   // ******************************************************
   // phase timer
   // ******************************************************
   // a fixed phase time stands in for the frame clock divider, which
   // lives outside this block
   wire tick_end = (tick_r == `LSW_PHASE_CYCLES - 1);

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         tick_r <= 16'h0000;
      else if (!drv_en | tick_end)
         tick_r <= 16'h0000;
      else
         tick_r <= tick_r + 16'h0001;
   end

   // ******************************************************
   // phase sequencer
   // ******************************************************
   // a disabled driver holds the sequence at phase A
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         phase_r       <= 3'd0;
         frame_start_r <= 1'b0;
      end
      else if (!drv_en)
      begin
         phase_r       <= 3'd0;
         frame_start_r <= 1'b0;
      end
      else if (tick_end)
      begin
         // step A.. up to the duty count, then wrap
         if (phase_r >= duty)
         begin
            phase_r       <= 3'd0;
            frame_start_r <= 1'b1;
         end
         else
         begin
            phase_r       <= phase_r + 3'd1;
            frame_start_r <= 1'b0;
         end
      end
      else
         frame_start_r <= 1'b0;
   end

   // ******************************************************
   // per-pin drive codes
   // ******************************************************
   wire [13:0] act_nxt;
   wire [13:0] bp_nxt;
   wire [13:0] lvl_nxt;
   wire [7:0]  bp_pat [0:13];
   reg  [7:0]  pb_nxt;
   integer     j;

   genvar      k;
   generate
      for (k = 0; k < `LSW_PIN_COUNT; k = k + 1)
      begin : g_pin
         wire [7:0] pat = segment_pattern_regs[k];
         wire       shw = act_nxt[k] & ~blank;
         assign act_nxt[k] = pen_r[k] & drv_en;
         assign bp_nxt[k]  = bpsel_r[k];
         // bit position equals phase, H at 7 .. A at 0
         assign lvl_nxt[k] = shw & pat[phase_r];
         assign bp_pat[k]  = (shw & bp_nxt[k]) ? pat : 8'h00;
      end
   endgenerate

   // record in which phases any shown backplane pin is active
   always @*
   begin
      pb_nxt = 8'h00;
      for (j = 0; j < `LSW_PIN_COUNT; j = j + 1)
         pb_nxt = pb_nxt | bp_pat[j];
   end

   // ******************************************************
   // output registers
   // ******************************************************
   // every output comes from a flop, one cycle after its source
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         pin_active_r <= 14'h0000;
      else
         pin_active_r <= act_nxt;
   end

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         pin_is_bp_r <= 14'h0000;
      else
         pin_is_bp_r <= bp_nxt;
   end

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         pin_level_r <= 14'h0000;
      else
         pin_level_r <= lvl_nxt;
   end

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         phase_backplane_r <= 8'h00;
      else
         phase_backplane_r <= pb_nxt;
   end

endmodule

//--- include/lsw_defines.vh
// register offsets, field positions, reset values and timing counts
// for the segment pattern map; included by the core file and the testbench
`ifndef LSW_DEFINES_VH
`define LSW_DEFINES_VH

`define LSW_OFS_CTRL      12'h000
`define LSW_OFS_PEN       12'h004
`define LSW_OFS_BPSEL     12'h008
`define LSW_OFS_STATUS    12'h00C
`define LSW_OFS_PAT_BASE  12'h040
`define LSW_OFS_PAT_LAST  12'h074
`define LSW_PIN_FIRST     6'd50
`define LSW_PIN_COUNT     14

`define LSW_CTRL_EN_BIT    7
`define LSW_CTRL_BLANK_BIT 6
`define LSW_CTRL_DUTY_HI   2
`define LSW_CTRL_DUTY_LO   0
`define LSW_CTRL_RESET     8'h00

`define LSW_PHASE_TIME_NS  32'd1000
`define LSW_CLK_PERIOD_NS  32'd50
`define LSW_PHASE_CYCLES   (`LSW_PHASE_TIME_NS / `LSW_CLK_PERIOD_NS)

`endif

//--- tb/lsw_panel_model.sv
// panel glass model: which segments light from the pin drive
// assumes drive codes straight from the segment map outputs
`timescale 1ns/10ps
module lsw_glass
(
   input  logic [13:0] act,
   input  logic [13:0] bp,
   input  logic [13:0] lvl,
   output logic [13:0] lit
);
   // a segment lights only while some backplane is active in the phase
   assign lit = act & ~bp & lvl & {14{|(act & bp & lvl)}};
endmodule

//--- tb/lsw_segment_map_assertions.sv
// checker on the top ports of the segment pattern map
// assumes a bind from the testbench top file
`timescale 1ns/10ps
module lsw_chk
(
   input logic        pclk,
   input logic        presetn,
   input logic        psel,
   input logic        penable,
   input logic        pwrite,
   input logic [31:0] prdata,
   input logic        pready,
   input logic        pslverr,
   input logic [13:0] pin_active_r,
   input logic [13:0] pin_is_bp_r,
   input logic [13:0] pin_level_r,
   input logic        frame_start_r
);
   // ****
   // properties
   // ****
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire wr = penable && pwrite;
   property p_ack; psel && !penable |=> pready; endproperty
   a_ack: assert property (p_ack) else $error("no ready");
   property p_ack_src; pready |-> $past(psel && !penable); endproperty
   a_ack_src: assert property (p_ack_src) else $error("stray ready");
   property p_err; pslverr |-> pready; endproperty
   a_err: assert property (p_err) else $error("error alone");
   property p_rd0; pready && !pwrite |-> prdata[31:14] == 18'h0; endproperty
   a_rd0: assert property (p_rd0) else $error("high bits set");
   property p_gate; (pin_level_r & ~pin_active_r) == 14'h0; endproperty
   a_gate: assert property (p_gate) else $error("idle pin driven");
   property p_frame; frame_start_r |=> !frame_start_r [*8]; endproperty
   a_frame: assert property (p_frame) else $error("frame too short");
   // enables only move after a register write lands
   property p_act; $changed(pin_active_r) |-> $past(wr) || $past(wr, 2);
   endproperty
   a_act: assert property (p_act) else $error("enable moved");
   property p_bp; $changed(pin_is_bp_r) |-> $past(wr) || $past(wr, 2);
   endproperty
   a_bp: assert property (p_bp) else $error("backplane moved");
   c_frame: cover property (frame_start_r);
   c_err: cover property (pslverr);
   c_lit: cover property (|pin_level_r);
endmodule

//--- tb/testbench.sv
// self-checking bench for the segment pattern map
// assumes checker and panel model compile before this file
`timescale 1ns/10ps
`include "lsw_defines.vh"
module testbench;
   logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = 12'h0;
   logic [31:0] pwdata = 32'h0, prdata, rdat;
   logic        pready, pslverr, frame_start_r, err;
   logic [13:0] pin_active_r, pin_is_bp_r, pin_level_r, lit;
   logic [7:0]  phase_backplane_r;
   int          miscompares = 0, samples_checked = 0, n;
   always #25 pclk = ~pclk;
   lsw_segment_map lsw_segment_map_inst (.*);
   lsw_glass lsw_glass_inst (.act(pin_active_r), .bp(pin_is_bp_r),
      .lvl(pin_level_r), .lit(lit));
   // ****
   // tasks
   // ****
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      do @(posedge pclk); while (pready !== 1'b1);
      rdat = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   task t_regs;
      apb(1, 12'h040, 32'ha5);
      apb(0, 12'h040, 32'h0);
      chk(rdat, 32'ha5);
      apb(0, 12'h100, 32'h0);
      chk({err, rdat[30:0]}, 32'h8000_0000);
   endtask
   task t_drive;
      apb(1, 12'h040, 32'h1);
      apb(1, 12'h044, 32'h1);
      apb(1, 12'h048, 32'h2);
      apb(1, 12'h008, 32'h1);
      apb(1, 12'h004, 32'h7);
      apb(1, 12'h000, 32'h1);
      chk(pin_active_r, 32'h0);
      apb(1, 12'h000, 32'h81);
      do @(posedge pclk); while (frame_start_r !== 1'b1);
      repeat (4) @(posedge pclk);
      chk(pin_is_bp_r, 32'h1);
      chk(pin_level_r, 32'h3);
      chk(lit, 32'h2);
      chk(phase_backplane_r, 32'h1);
      repeat (`LSW_PHASE_CYCLES) @(posedge pclk);
      chk(pin_level_r, 32'h4);
      chk(lit, 32'h0);
      n = 4 + `LSW_PHASE_CYCLES;
      do @(posedge pclk); while (++n < 999 && frame_start_r !== 1'b1);
      chk(n, 2 * `LSW_PHASE_CYCLES);
   endtask
   task t_blank;
      apb(1, 12'h000, 32'hc1);
      repeat (3) @(posedge pclk);
      chk(pin_level_r, 32'h0);
      chk(pin_active_r, 32'h7);
      apb(1, 12'h000, 32'h1);
      repeat (3) @(posedge pclk);
      chk(pin_active_r, 32'h0);
   endtask
   task tally_and_finish;
      $display("miscompares %0d samples_checked %0d", miscompares,
         samples_checked);
      if (miscompares == 0 && samples_checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // run needs some 130 cycles; 2000 leaves ample margin
   initial
   begin
      #100000;
      miscompares++;
      tally_and_finish;
   end
   initial
   begin
      repeat (5) @(posedge pclk);
      presetn <= 1;
      t_regs;
      t_drive;
      t_blank;
      tally_and_finish;
   end
endmodule
bind lsw_segment_map lsw_chk lsw_chk_inst (.*);
